// [ntpe_cfg.svh]
// Offsets, field positions and reset values of the port event and PM logic
`ifndef NTPE_CFG_SVH
`define NTPE_CFG_SVH
`define NTPE_OFF_CMD 13'h0004
`define NTPE_OFF_LCMD 13'h1004
`define NTPE_OFF_IOCTL 13'h01c8
`define NTPE_OFF_LIOCTL 13'h11c8
`define NTPE_OFF_ROMSZ 13'h0268
`define NTPE_OFF_INGR 13'h0660
`define NTPE_OFF_TCX 13'h0960
`define NTPE_OFF_EVST 13'h0fe0
`define NTPE_OFF_EVMK 13'h0fe4
`define NTPE_OFF_DBST 13'h01f0
`define NTPE_OFF_DBMK 13'h01f4
`define NTPE_OFF_MODE 13'h01f8
`define NTPE_OFF_PMC 13'h01fc
`define NTPE_BIT_INTDIS 10
`define NTPE_BIT_IO_DB 7
`define NTPE_BIT_IO_ERR 5
`define NTPE_BIT_ROMSZ 16
`define NTPE_BIT_ROMVIRT 23
`define NTPE_BIT_PM_LDOWN 16
`define NTPE_BIT_PM_L23 17
`define NTPE_RST_EVMK 4'hf
`define NTPE_RST_DBMK 2'h3
`define NTPE_DSTATE_SLEEP 2'h3
`define NTPE_MAX_DS 8
`endif

// [ntpe_pkg.sv]
// Types of the port event and PM logic
`default_nettype none
package ntpe_pkg;
    typedef enum logic [2:0] {
        NTPE_MWR = 3'h0,
        NTPE_MRD = 3'h1,
        NTPE_CPL = 3'h2,
        NTPE_CFG = 3'h3,
        NTPE_MSG_INTX = 3'h4,
        NTPE_MSG_UERR = 3'h5,
        NTPE_MSG_OTHER = 3'h6
    } ntpe_kind_t;
    typedef enum logic [3:0] {
        NTPE_PM_IDLE = 4'h1,
        NTPE_PM_DRAIN = 4'h2,
        NTPE_PM_ACK = 4'h4,
        NTPE_PM_L23 = 4'h8
    } ntpe_pm_t;
    typedef enum logic [2:0] {
        NTPE_UP_IDLE = 3'h1,
        NTPE_UP_WAIT = 3'h2,
        NTPE_UP_ACK = 3'h4
    } ntpe_up_t;
    typedef struct packed {
        logic cmd_virt_intdis;
        logic cmd_link_intdis;
        logic io_virt_db;
        logic io_virt_err;
        logic io_link_db;
        logic rom_32k;
        logic rom_virt;
        logic [2:0] tc_prog;
        logic [3:0] ev_stat;
        logic [3:0] ev_mask;
        logic [1:0] db_stat;
        logic [1:0] db_mask;
        logic [1:0] msi_en;
        logic [1:0] d_state;
        logic [1:0] aspm_link;
        logic [1:0] aspm_virt;
        logic link_down_q;
        logic [31:0] rdata;
        logic tlp_vld;
        logic [2:0] tlp_tc;
        logic tlp_drop;
        logic malformed;
        logic virt_intx;
        logic link_intx;
        logic virt_msi;
        logic link_msi;
        logic virt_msi_lvl;
        logic link_msi_lvl;
        logic wired_n;
        ntpe_pm_t pm_st;
        logic pme_ack;
        ntpe_up_t up_st;
        logic bcast;
        logic up_ack;
        logic [7:0] ds_acks;
    } ntpe_state_t;
endpackage : ntpe_pkg
`default_nettype wire

// [ntpe_tc_xlate.sv]
// Traffic class rewrite for one header
`timescale 1ns/1ns
`default_nettype none
module ntpe_tc_xlate (
    // Header in
    input wire ntpe_pkg::ntpe_kind_t kind_i,
    input wire logic [2:0] tc_i,
    input wire logic [2:0] prog_i,
    // Header out
    output logic [2:0] tc_o
);
    import ntpe_pkg::*;
    always_comb begin
        tc_o = tc_i;
        case (kind_i)
            // A programmed class of zero leaves writes and reads untouched
            NTPE_MWR: begin
                if (prog_i != 3'h0) tc_o = prog_i;
            end
            NTPE_MRD: begin
                if (prog_i != 3'h0) tc_o = prog_i;
            end
            NTPE_CPL: begin
                tc_o = 3'h0;
            end
            default: begin
                tc_o = tc_i;
            end
        endcase
    end
endmodule : ntpe_tc_xlate
`default_nettype wire

// [ntpe_top.sv]
// Interrupt, traffic class, PM and ROM control of the nontransparent port
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "ntpe_cfg.svh"
// How it works
// - Posted writes take programmed nonzero traffic class
// - Reads take programmed class; completions return TC0
// - Link side ASPM L0s/L1; virtual never sleeps
// - Sleep state requests L1, drops non-cfg/msg
// - Turn-off acked only once upstream queue empty
// - After ack, request L2/L3 ready state
// - Upstream broadcasts turn-off, aggregates all acks
// - Virtual endpoint never enters L1
// - No PME generation; no slot power messages
// - ROM on link by default, never both
// - ROM size bit selects 16 or 32 KB
// - Received INTx message counts as malformed
// - Five virtual sources, all masked after reset
// - Per source, INTx, MSI, wired pin mutually exclusive
// - Bits 7/5 route doorbell/errors to pin
// - Disable, mask, link down, clear drop interrupt
// - Bridge secondary reset drops virtual interrupt
// - Correctable error sets status bit 0
// - Uncorrectable error sets status bit 1
// - Both link-down edges set bit 2
// - Uncorrectable error message sets bit 3
// - Link side interrupts only for doorbells
module ntpe_top #(
    parameter int DS_PORTS = 3
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    // Register port
    input wire logic [12:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // Header stream
    input wire logic TLP_VLD_I,
    input wire ntpe_pkg::ntpe_kind_t TLP_KIND_I,
    input wire logic [2:0] TLP_TC_I,
    output logic TLP_VLD_O,
    output logic [2:0] TLP_TC_O,
    output logic TLP_DROP_O,
    output logic MALFORMED_O,
    // Event sources
    input wire logic LS_CORR_ERR_I,
    input wire logic LS_UNCORR_ERR_I,
    input wire logic LINK_LAYER_DOWN_STATE_I,
    input wire logic HOT_RESET_I,
    input wire logic BRIDGE_MODE_I,
    input wire logic SEC_BUS_RESET_I,
    input wire logic VIRT_DOORBELL_I,
    input wire logic LINK_DOORBELL_I,
    // Interrupt outputs
    output logic VIRT_INTX_O,
    output logic VIRT_MSI_O,
    output logic LINK_INTX_O,
    output logic LINK_MSI_O,
    output logic WIRED_INTERRUPT_OUT_N_O,
    // Power management
    input wire logic PME_TURN_OFF_I,
    input wire logic UPSTREAM_PENDING_I,
    input wire logic UP_TURN_OFF_I,
    input wire logic UP_PENDING_I,
    input wire logic [`NTPE_MAX_DS-1:0] DS_ACK_I,
    output logic PME_TO_ACK_O,
    output logic L23_REQ_O,
    output logic L1_REQ_O,
    output logic ASPM_L0S_EN_O,
    output logic ASPM_L1_EN_O,
    output logic BCAST_TURN_OFF_O,
    output logic UP_PME_TO_ACK_O,
    // Expansion ROM
    output logic ROM_VIRT_EN_O,
    output logic ROM_LINK_EN_O,
    output logic ROM_SIZE_32K_O
);
    import ntpe_pkg::*;

    if (DS_PORTS < 1 || DS_PORTS > `NTPE_MAX_DS) begin : g_bad_ports
        $error("DS_PORTS must lie between 1 and 8");
    end

    // Bit for each downstream port that must answer
    localparam logic [7:0] DS_MASK = 8'((9'h1 << DS_PORTS) - 9'h1);

    ntpe_state_t s;
    ntpe_state_t next_s;
    logic [2:0] xl_tc;
    logic wr_hit_evst;
    logic virt_db_act;
    logic virt_ev_act;
    logic virt_gate;
    logic link_db_act;
    logic link_gate;
    logic virt_soft;
    logic link_soft;
    logic all_acked;
    logic sleep;

    ntpe_tc_xlate u_tc (
        .kind_i(TLP_KIND_I),
        .tc_i(TLP_TC_I),
        .prog_i(s.tc_prog),
        .tc_o(xl_tc)
    );

    always_comb begin
        next_s = s;
        sleep = (s.d_state == `NTPE_DSTATE_SLEEP);
        wr_hit_evst = REG_WR_I && (REG_ADDR_I == `NTPE_OFF_EVST);
        // Register writes
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                `NTPE_OFF_CMD: next_s.cmd_virt_intdis = REG_WDATA_I[`NTPE_BIT_INTDIS];
                `NTPE_OFF_LCMD: next_s.cmd_link_intdis = REG_WDATA_I[`NTPE_BIT_INTDIS];
                `NTPE_OFF_IOCTL: begin
                    next_s.io_virt_db = REG_WDATA_I[`NTPE_BIT_IO_DB];
                    next_s.io_virt_err = REG_WDATA_I[`NTPE_BIT_IO_ERR];
                end
                `NTPE_OFF_LIOCTL: next_s.io_link_db = REG_WDATA_I[`NTPE_BIT_IO_DB];
                `NTPE_OFF_ROMSZ: next_s.rom_32k = REG_WDATA_I[`NTPE_BIT_ROMSZ];
                `NTPE_OFF_INGR: next_s.rom_virt = REG_WDATA_I[`NTPE_BIT_ROMVIRT];
                `NTPE_OFF_TCX: next_s.tc_prog = REG_WDATA_I[2:0];
                `NTPE_OFF_EVMK: next_s.ev_mask = REG_WDATA_I[3:0];
                `NTPE_OFF_DBMK: next_s.db_mask = REG_WDATA_I[1:0];
                `NTPE_OFF_MODE: next_s.msi_en = REG_WDATA_I[1:0];
                `NTPE_OFF_PMC: begin
                    next_s.d_state = REG_WDATA_I[1:0];
                    next_s.aspm_link = REG_WDATA_I[3:2];
                    next_s.aspm_virt = REG_WDATA_I[5:4];
                end
                default: begin
                end
            endcase
        end
        // Sticky event bits; a set in the clearing cycle wins
        next_s.link_down_q = LINK_LAYER_DOWN_STATE_I;
        next_s.ev_stat = s.ev_stat & ~(wr_hit_evst ? REG_WDATA_I[3:0] : 4'h0);
        if (LS_CORR_ERR_I) next_s.ev_stat[0] = 1'b1;
        if (LS_UNCORR_ERR_I) next_s.ev_stat[1] = 1'b1;
        if (LINK_LAYER_DOWN_STATE_I != s.link_down_q) next_s.ev_stat[2] = 1'b1;
        if (TLP_VLD_I && TLP_KIND_I == NTPE_MSG_UERR) next_s.ev_stat[3] = 1'b1;
        // Doorbells: writing one clears, the request wins
        next_s.db_stat = s.db_stat;
        if (REG_WR_I && REG_ADDR_I == `NTPE_OFF_DBST) begin
            next_s.db_stat = s.db_stat & ~REG_WDATA_I[1:0];
        end
        if (VIRT_DOORBELL_I) next_s.db_stat[0] = 1'b1;
        if (LINK_DOORBELL_I) next_s.db_stat[1] = 1'b1;
        // Interrupt routing for the virtual and link sides
        virt_db_act = s.db_stat[0] & ~s.db_mask[0];
        virt_ev_act = |(s.ev_stat & ~s.ev_mask);
        virt_gate = ~s.cmd_virt_intdis & ~LINK_LAYER_DOWN_STATE_I & ~HOT_RESET_I
                  & ~(BRIDGE_MODE_I & SEC_BUS_RESET_I);
        // Each source goes to the pin or to messages, never both
        virt_soft = virt_gate & ((virt_db_act & ~s.io_virt_db)
                  | (virt_ev_act & ~s.io_virt_err));
        link_db_act = s.db_stat[1] & ~s.db_mask[1];
        link_gate = ~s.cmd_link_intdis & ~LINK_LAYER_DOWN_STATE_I & ~HOT_RESET_I;
        link_soft = link_gate & link_db_act & ~s.io_link_db;
        next_s.virt_intx = virt_soft & ~s.msi_en[0];
        next_s.link_intx = link_soft & ~s.msi_en[1];
        next_s.virt_msi_lvl = virt_soft & s.msi_en[0];
        next_s.link_msi_lvl = link_soft & s.msi_en[1];
        // MSI is an edge: one message per newly pending interrupt
        next_s.virt_msi = virt_soft & s.msi_en[0] & ~s.virt_msi_lvl;
        next_s.link_msi = link_soft & s.msi_en[1] & ~s.link_msi_lvl;
        next_s.wired_n = ~((virt_gate & ((virt_db_act & s.io_virt_db)
                       | (virt_ev_act & s.io_virt_err)))
                       | (link_gate & link_db_act & s.io_link_db));
        // Header path
        next_s.tlp_vld = TLP_VLD_I;
        next_s.tlp_tc = xl_tc;
        next_s.malformed = TLP_VLD_I && TLP_KIND_I == NTPE_MSG_INTX;
        next_s.tlp_drop = 1'b0;
        if (TLP_VLD_I) begin
            case (TLP_KIND_I)
                NTPE_MWR, NTPE_MRD, NTPE_CPL: next_s.tlp_drop = sleep;
                NTPE_MSG_INTX, NTPE_MSG_UERR: next_s.tlp_drop = 1'b1;
                default: next_s.tlp_drop = 1'b0;
            endcase
        end
        // Link endpoint turn-off handshake; no PME message is ever made
        next_s.pme_ack = 1'b0;
        case (s.pm_st)
            NTPE_PM_IDLE: begin
                if (PME_TURN_OFF_I) next_s.pm_st = NTPE_PM_DRAIN;
            end
            NTPE_PM_DRAIN: begin
                if (!UPSTREAM_PENDING_I) begin
                    next_s.pm_st = NTPE_PM_ACK;
                    next_s.pme_ack = 1'b1;
                end
            end
            NTPE_PM_ACK: begin
                next_s.pm_st = NTPE_PM_L23;
            end
            NTPE_PM_L23: begin
                if (LINK_LAYER_DOWN_STATE_I) next_s.pm_st = NTPE_PM_IDLE;
            end
            default: begin
                next_s.pm_st = NTPE_PM_IDLE;
            end
        endcase
        if (HOT_RESET_I) next_s.pm_st = NTPE_PM_IDLE;
        // Upstream port aggregation; the virtual endpoint answers at once
        all_acked = &(s.ds_acks | ~DS_MASK);
        next_s.bcast = 1'b0;
        next_s.up_ack = 1'b0;
        case (s.up_st)
            NTPE_UP_IDLE: begin
                if (UP_TURN_OFF_I) begin
                    next_s.up_st = NTPE_UP_WAIT;
                    next_s.bcast = 1'b1;
                    next_s.ds_acks = 8'h00;
                end
            end
            NTPE_UP_WAIT: begin
                next_s.ds_acks = s.ds_acks | DS_ACK_I;
                if (all_acked && !UP_PENDING_I) begin
                    next_s.up_st = NTPE_UP_ACK;
                    next_s.up_ack = 1'b1;
                end
            end
            NTPE_UP_ACK: begin
                next_s.up_st = NTPE_UP_IDLE;
            end
            default: begin
                next_s.up_st = NTPE_UP_IDLE;
            end
        endcase
        // Register read, answered in the next cycle
        next_s.rdata = 32'h0000_0000;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                `NTPE_OFF_CMD: next_s.rdata[`NTPE_BIT_INTDIS] = s.cmd_virt_intdis;
                `NTPE_OFF_LCMD: next_s.rdata[`NTPE_BIT_INTDIS] = s.cmd_link_intdis;
                `NTPE_OFF_IOCTL: begin
                    next_s.rdata[`NTPE_BIT_IO_DB] = s.io_virt_db;
                    next_s.rdata[`NTPE_BIT_IO_ERR] = s.io_virt_err;
                end
                `NTPE_OFF_LIOCTL: next_s.rdata[`NTPE_BIT_IO_DB] = s.io_link_db;
                `NTPE_OFF_ROMSZ: next_s.rdata[`NTPE_BIT_ROMSZ] = s.rom_32k;
                `NTPE_OFF_INGR: next_s.rdata[`NTPE_BIT_ROMVIRT] = s.rom_virt;
                `NTPE_OFF_TCX: next_s.rdata[2:0] = s.tc_prog;
                `NTPE_OFF_EVST: next_s.rdata[3:0] = s.ev_stat;
                `NTPE_OFF_EVMK: next_s.rdata[3:0] = s.ev_mask;
                `NTPE_OFF_DBST: next_s.rdata[1:0] = s.db_stat;
                `NTPE_OFF_DBMK: next_s.rdata[1:0] = s.db_mask;
                `NTPE_OFF_MODE: next_s.rdata[1:0] = s.msi_en;
                `NTPE_OFF_PMC: begin
                    next_s.rdata[5:0] = {s.aspm_virt, s.aspm_link, s.d_state};
                    next_s.rdata[`NTPE_BIT_PM_LDOWN] = s.link_down_q;
                    next_s.rdata[`NTPE_BIT_PM_L23] = (s.pm_st == NTPE_PM_L23);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s <= '0;
            s.ev_mask <= `NTPE_RST_EVMK;
            s.db_mask <= `NTPE_RST_DBMK;
            s.wired_n <= 1'b1;
            s.pm_st <= NTPE_PM_IDLE;
            s.up_st <= NTPE_UP_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign REG_RDATA_O = s.rdata;
    assign TLP_VLD_O = s.tlp_vld;
    assign TLP_TC_O = s.tlp_tc;
    assign TLP_DROP_O = s.tlp_drop;
    assign MALFORMED_O = s.malformed;
    assign VIRT_INTX_O = s.virt_intx;
    assign VIRT_MSI_O = s.virt_msi;
    assign LINK_INTX_O = s.link_intx;
    assign LINK_MSI_O = s.link_msi;
    assign WIRED_INTERRUPT_OUT_N_O = s.wired_n;
    assign PME_TO_ACK_O = s.pme_ack;
    assign L23_REQ_O = (s.pm_st == NTPE_PM_L23);
    // Only the link side has a physical link to sleep; the virtual bits are stored only
    assign L1_REQ_O = (s.d_state == `NTPE_DSTATE_SLEEP);
    assign ASPM_L0S_EN_O = s.aspm_link[0];
    assign ASPM_L1_EN_O = s.aspm_link[1];
    assign BCAST_TURN_OFF_O = s.bcast;
    assign UP_PME_TO_ACK_O = s.up_ack;
    assign ROM_VIRT_EN_O = s.rom_virt;
    assign ROM_LINK_EN_O = ~s.rom_virt;
    assign ROM_SIZE_32K_O = s.rom_32k;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESETN_I);

    sequence s_turn_off_drained;
        (s.pm_st == NTPE_PM_DRAIN) && !UPSTREAM_PENDING_I && !HOT_RESET_I;
    endsequence
    sequence s_ack_then_l23;
        PME_TO_ACK_O ##1 L23_REQ_O;
    endsequence

    property p_tc_post;
        TLP_VLD_I && TLP_KIND_I == NTPE_MWR && s.tc_prog != 3'h0
            |=> TLP_TC_O == $past(s.tc_prog);
    endproperty
    a_tc_post: assert property (p_tc_post) else $error("posted write class wrong");
    property p_cpl_tc0;
        TLP_VLD_I && TLP_KIND_I == NTPE_CPL |=> TLP_TC_O == 3'h0;
    endproperty
    a_cpl_tc0: assert property (p_cpl_tc0) else $error("completion class not zero");
    property p_sleep_drop;
        TLP_VLD_I && TLP_KIND_I == NTPE_MWR && s.d_state == `NTPE_DSTATE_SLEEP
            && !(REG_WR_I && REG_ADDR_I == `NTPE_OFF_PMC)
            |=> TLP_DROP_O && L1_REQ_O;
    endproperty
    a_sleep_drop: assert property (p_sleep_drop) else $error("sleep did not drop");
    property p_ack_drained;
        $rose(PME_TO_ACK_O) |-> $past(!UPSTREAM_PENDING_I);
    endproperty
    a_ack_drained: assert property (p_ack_drained) else $error("ack with queue busy");
    property p_l23_after_ack;
        // A hot reset during the ack cycle legally returns the machine to idle
        s_turn_off_drained ##1 !HOT_RESET_I |-> s_ack_then_l23;
    endproperty
    a_l23_after_ack: assert property (p_l23_after_ack) else $error("no L23 after ack");
    property p_up_ack;
        UP_PME_TO_ACK_O |-> $past(all_acked && !UP_PENDING_I && s.up_st == NTPE_UP_WAIT);
    endproperty
    a_up_ack: assert property (p_up_ack) else $error("early aggregate ack");
    property p_malformed;
        TLP_VLD_I && TLP_KIND_I == NTPE_MSG_INTX |=> MALFORMED_O && TLP_DROP_O;
    endproperty
    a_malformed: assert property (p_malformed) else $error("INTx not malformed");
    property p_corr_set;
        LS_CORR_ERR_I ##1 !(wr_hit_evst && REG_WDATA_I[0]) |-> s.ev_stat[0] [*2];
    endproperty
    a_corr_set: assert property (p_corr_set) else $error("bit 0 not sticky");
    property p_down_edge;
        $changed(LINK_LAYER_DOWN_STATE_I) |=> s.ev_stat[2];
    endproperty
    a_down_edge: assert property (p_down_edge) else $error("edge missed");
    property p_intdis;
        s.cmd_virt_intdis || LINK_LAYER_DOWN_STATE_I |=> !VIRT_INTX_O && !VIRT_MSI_O;
    endproperty
    a_intdis: assert property (p_intdis) else $error("virtual interrupt not dropped");
    property p_excl;
        !(VIRT_INTX_O && s.virt_msi_lvl) && !(LINK_INTX_O && s.link_msi_lvl);
    endproperty
    a_excl: assert property (p_excl) else $error("INTx and MSI together");
endmodule : ntpe_top
`default_nettype wire

// [ntpe_ds_model.sv]
// Downstream port model that answers a broadcast turn-off
`timescale 1ns/1ns
`default_nettype none
module ntpe_ds_model #(
    parameter int N = 3,
    parameter int GAP = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Turn-off in, acks out
    input wire logic bcast_i,
    output logic [7:0] ack_o
);
    int cnt;
    // Ports answer one after another, so the aggregate has to wait for the slowest
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
        end else if (bcast_i) begin
            cnt <= 1;
        end else if (cnt != 0 && cnt < GAP * N + 2) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
    end
    always_comb begin
        ack_o = '0;
        for (int i = 0; i < N; i++) begin
            ack_o[i] = (cnt == GAP * (i + 1));
        end
    end
endmodule : ntpe_ds_model
`default_nettype wire

// [nt_port_event_pm_tc_logic_tb.sv]
// Self-checking bench of the port event, PM and traffic class logic
`timescale 1ns/1ns
`default_nettype none
`include "ntpe_cfg.svh"
module nt_port_event_pm_tc_logic_tb;
    import ntpe_pkg::*;
    logic clk, rstn, wr, rd, vld, ldn, hrst, brg, sbr, pto, upend, uto, upp;
    logic [12:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] ev;
    ntpe_kind_t kind;
    logic [2:0] tci, tco;
    logic [7:0] dsack;
    logic vo, drop, malf, vintx, vmsi, lintx, lmsi, wired_n, pack, l23, l1;
    logic l0s_en, l1_en, bcast, upack, romv, roml, rom32;
    int err_count, n_compared;
    ntpe_top #(.DS_PORTS(3)) u_ntpe_top (
        .CLK_SYS_I(clk), .RESETN_I(rstn), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .TLP_VLD_I(vld),
        .TLP_KIND_I(kind), .TLP_TC_I(tci), .TLP_VLD_O(vo), .TLP_TC_O(tco),
        .TLP_DROP_O(drop), .MALFORMED_O(malf), .LS_CORR_ERR_I(ev[0]),
        .LS_UNCORR_ERR_I(ev[1]), .LINK_LAYER_DOWN_STATE_I(ldn), .HOT_RESET_I(hrst),
        .BRIDGE_MODE_I(brg), .SEC_BUS_RESET_I(sbr), .VIRT_DOORBELL_I(ev[2]),
        .LINK_DOORBELL_I(ev[3]), .VIRT_INTX_O(vintx), .VIRT_MSI_O(vmsi),
        .LINK_INTX_O(lintx), .LINK_MSI_O(lmsi), .WIRED_INTERRUPT_OUT_N_O(wired_n),
        .PME_TURN_OFF_I(pto), .UPSTREAM_PENDING_I(upend), .UP_TURN_OFF_I(uto),
        .UP_PENDING_I(upp), .DS_ACK_I(dsack), .PME_TO_ACK_O(pack), .L23_REQ_O(l23),
        .L1_REQ_O(l1), .ASPM_L0S_EN_O(l0s_en), .ASPM_L1_EN_O(l1_en),
        .BCAST_TURN_OFF_O(bcast), .UP_PME_TO_ACK_O(upack), .ROM_VIRT_EN_O(romv),
        .ROM_LINK_EN_O(roml), .ROM_SIZE_32K_O(rom32)
    );
    ntpe_ds_model #(.N(3), .GAP(2)) u_ntpe_ds_model (
        .clk_i(clk), .rstn_i(rstn), .bcast_i(bcast), .ack_o(dsack)
    );
    task automatic print_verdict();
        $display("Checks %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    task automatic tmo(input string nm);
        err_count++;
        $display("ERROR %s wait ran out", nm);
        print_verdict();
    endtask : tmo
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32
    task automatic chk1(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitc
    task automatic wreg(input logic [12:0] a, input logic [31:0] d);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
        @(posedge clk) wr <= 1'b0;
    endtask : wreg
    task automatic rdc(input logic [12:0] a, input logic [31:0] e, input string nm);
        @(posedge clk) begin rd <= 1'b1; addr <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 chk32(nm, e, rdata);
    endtask : rdc
    task automatic hdr(input ntpe_kind_t k, input logic [2:0] tc);
        @(posedge clk) begin vld <= 1'b1; kind <= k; tci <= tc; end
        @(posedge clk) vld <= 1'b0;
        #1 chk1("hdr_vld", 1'b1, vo);
    endtask : hdr
    // Outputs follow one edge after the status bit; an MSI pulse stands only then
    task automatic evp(input logic [3:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 4'h0;
        waitc(1);
    endtask : evp
    task automatic t_reset();
        chk1("wired_n", 1'b1, wired_n);
        chk1("rom_link", 1'b1, roml);
        chk1("rom_virt", 1'b0, romv);
        rdc(`NTPE_OFF_EVMK, 32'h0000000f, "ev_mask");
        rdc(`NTPE_OFF_DBMK, 32'h00000003, "db_mask");
        rdc(13'h0100, 32'h00000000, "unmapped");
    endtask : t_reset
    task automatic t_tc();
        wreg(`NTPE_OFF_TCX, 32'h5);
        hdr(NTPE_MWR, 3'h0); chk32("tc_mwr", 32'h5, tco);
        hdr(NTPE_MRD, 3'h0); chk32("tc_mrd", 32'h5, tco);
        hdr(NTPE_CPL, 3'h5); chk32("tc_cpl", 32'h0, tco);
        wreg(`NTPE_OFF_TCX, 32'h7);
        hdr(NTPE_MWR, 3'h2); chk32("tc_max", 32'h7, tco);
        hdr(NTPE_MSG_INTX, 3'h0); chk1("malformed", 1'b1, malf);
        chk1("intx_drop", 1'b1, drop);
    endtask : t_tc
    task automatic t_ev();
        wreg(`NTPE_OFF_EVMK, 32'h0);
        evp(4'h1); chk1("corr_int", 1'b1, vintx);
        rdc(`NTPE_OFF_EVST, 32'h1, "corr_stat");
        wreg(`NTPE_OFF_CMD, 32'h1 << `NTPE_BIT_INTDIS); waitc(2);
        chk1("intdis", 1'b0, vintx);
        wreg(`NTPE_OFF_CMD, 32'h0); wreg(`NTPE_OFF_IOCTL, 32'h20); waitc(2);
        chk1("wired_err", 1'b0, wired_n);
        chk1("excl", 1'b0, vintx);
        wreg(`NTPE_OFF_IOCTL, 32'h0); brg <= 1'b1; sbr <= 1'b1; waitc(3);
        chk1("sec_reset", 1'b0, vintx);
        brg <= 1'b0; sbr <= 1'b0; waitc(3); chk1("sticky", 1'b1, vintx);
        wreg(`NTPE_OFF_EVST, 32'h1); waitc(2); chk1("w1c", 1'b0, vintx);
        rdc(`NTPE_OFF_EVST, 32'h0, "ev_clr");
        evp(4'h2); rdc(`NTPE_OFF_EVST, 32'h2, "uncorr");
        wreg(`NTPE_OFF_EVST, 32'h2); ldn <= 1'b1; waitc(3);
        chk1("down_gate", 1'b0, vintx);
        rdc(`NTPE_OFF_EVST, 32'h4, "down_rise");
        wreg(`NTPE_OFF_EVST, 32'h4); ldn <= 1'b0; waitc(3);
        rdc(`NTPE_OFF_EVST, 32'h4, "down_fall");
        chk1("chg_int", 1'b1, vintx);
        wreg(`NTPE_OFF_EVST, 32'h4);
        hdr(NTPE_MSG_UERR, 3'h0); chk1("uerr_drop", 1'b1, drop);
        rdc(`NTPE_OFF_EVST, 32'h8, "uerr_msg");
        wreg(`NTPE_OFF_EVST, 32'h8); wreg(`NTPE_OFF_EVMK, 32'hf);
        evp(4'h1); chk1("masked", 1'b0, vintx);
        wreg(`NTPE_OFF_EVST, 32'h1);
    endtask : t_ev
    task automatic t_db();
        wreg(`NTPE_OFF_DBMK, 32'h0);
        evp(4'h8); chk1("link_intx", 1'b1, lintx);
        chk1("virt_quiet", 1'b0, vintx);
        wreg(`NTPE_OFF_DBST, 32'h2); wreg(`NTPE_OFF_MODE, 32'h3); waitc(2);
        chk1("db_clr", 1'b0, lintx);
        evp(4'h8); chk1("link_msi", 1'b1, lmsi);
        chk1("no_intx", 1'b0, lintx);
        waitc(1); chk1("msi_pulse", 1'b0, lmsi);
        evp(4'h4); chk1("virt_msi", 1'b1, vmsi);
        chk1("virt_no_intx", 1'b0, vintx);
        wreg(`NTPE_OFF_DBST, 32'h3); wreg(`NTPE_OFF_MODE, 32'h0);
        wreg(`NTPE_OFF_LIOCTL, 32'h80); evp(4'h8);
        chk1("link_wired", 1'b0, wired_n);
        hrst <= 1'b1; waitc(3); chk1("hot_gate", 1'b1, wired_n);
        hrst <= 1'b0; wreg(`NTPE_OFF_DBST, 32'h2); wreg(`NTPE_OFF_LIOCTL, 32'h0);
        wreg(`NTPE_OFF_IOCTL, 32'h80); evp(4'h4);
        chk1("virt_db_pin", 1'b0, wired_n);
        wreg(`NTPE_OFF_DBST, 32'h1); waitc(2);
        chk1("db_w1c", 1'b1, wired_n);
        wreg(`NTPE_OFF_IOCTL, 32'h0); wreg(`NTPE_OFF_DBMK, 32'h3);
    endtask : t_db
    task automatic t_pm();
        int i;
        wreg(`NTPE_OFF_PMC, 32'hc); waitc(2);
        chk1("l0s_en", 1'b1, l0s_en);
        chk1("l1_en", 1'b1, l1_en);
        upend <= 1'b1;
        @(posedge clk) pto <= 1'b1;
        @(posedge clk) pto <= 1'b0;
        waitc(5); chk1("ack_held", 1'b0, pack);
        upend <= 1'b0;
        for (i = 0; i < 20 && pack !== 1'b1; i++) waitc(1);
        if (i == 20) tmo("pme_ack");
        waitc(1); chk1("l23", 1'b1, l23);
        chk1("ack_once", 1'b0, pack);
        hrst <= 1'b1; waitc(2); chk1("l23_off", 1'b0, l23);
        hrst <= 1'b0;
    endtask : t_pm
    task automatic t_sleep_rom();
        wreg(`NTPE_OFF_PMC, 32'h3); waitc(2); chk1("l1_req", 1'b1, l1);
        hdr(NTPE_MWR, 3'h0); chk1("sleep_drop", 1'b1, drop);
        hdr(NTPE_CFG, 3'h0); chk1("cfg_pass", 1'b0, drop);
        wreg(`NTPE_OFF_PMC, 32'h0);
        wreg(`NTPE_OFF_ROMSZ, 32'h1 << `NTPE_BIT_ROMSZ);
        wreg(`NTPE_OFF_INGR, 32'h1 << `NTPE_BIT_ROMVIRT); waitc(2);
        chk1("rom_v", 1'b1, romv);
        chk1("rom_l", 1'b0, roml);
        chk1("rom_32k", 1'b1, rom32);
    endtask : t_sleep_rom
    task automatic t_up();
        int i;
        @(posedge clk) uto <= 1'b1;
        @(posedge clk) uto <= 1'b0;
        #1 chk1("bcast", 1'b1, bcast);
        waitc(3); chk1("up_early", 1'b0, upack);
        upp <= 1'b1; waitc(8); chk1("up_pend", 1'b0, upack);
        upp <= 1'b0;
        for (i = 0; i < 20 && upack !== 1'b1; i++) waitc(1);
        if (i == 20) tmo("up_ack");
        chk1("up_ack", 1'b1, upack);
    endtask : t_up
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rstn, wr, rd, vld, ldn, hrst, brg, sbr, pto, upend, uto, upp} = '0;
        addr = '0; wdata = '0; ev = '0; kind = NTPE_MWR; tci = '0;
        err_count = 0; n_compared = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        waitc(1);
        t_reset(); t_tc(); t_ev(); t_db(); t_pm(); t_sleep_rom(); t_up();
        print_verdict();
    end
endmodule : nt_port_event_pm_tc_logic_tb
`default_nettype wire
